// File: core/pelm_monitor.sv
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/10ps
module pelm_monitor #(
	parameter int unsigned MAX_REVS = pelm_pkg::MAX_REVS_DEF // Max limit in revs
) (
	input wire logic i_core_clk, // Core clock
	input wire logic i_sys_rst, // Sync reset, high
	input wire logic i_clk_en, // Freeze when low
	input wire logic [pelm_pkg::AW-1:0] i_addr, // Register address
	input wire logic [pelm_pkg::DW-1:0] i_wdata, // Write data
	input wire logic i_wr, // Write strobe
	input wire logic i_rd, // Read strobe
	input wire logic i_seq_access, // Access from sequence
	output logic [pelm_pkg::DW-1:0] o_rdata, // Read data
	input wire logic signed [pelm_pkg::DW-1:0] i_pos_err, // Measured error
	input wire logic i_pos_err_valid, // Error sample valid
	input wire logic i_nv_valid, // Saved image exists
	input wire pelm_pkg::pelm_nv_t i_nv_data, // Saved image
	output logic o_nv_save, // Save pulse
	output pelm_pkg::pelm_nv_t o_nv_data, // Image to save
	output logic [pelm_pkg::DW-1:0] o_pos_err_limit, // Active limit
	output logic [pelm_pkg::DW-1:0] o_velocity_limit, // Active vel limit
	output pelm_pkg::pelm_alarm_t o_alarm, // Alarm report
	output logic o_irq // Interrupt, high
);
	import pelm_pkg::*;

	// Scale revs to user units through gearing, saturating
	function automatic logic [DW-1:0] scale_revs(
		input logic [DW-1:0] distance_per_rev,
		input logic [DW-1:0] ga,
		input logic [DW-1:0] gb,
		input logic [DW-1:0] revs
	);
		logic [95:0] prod;
		prod = 96'(distance_per_rev) * 96'(ga) * 96'(revs);
		prod = prod / 96'(gb);
		if (prod > 96'(VAL_SAT)) begin
			return VAL_SAT;
		end
		return prod[DW-1:0];
	endfunction

	// Magnitude of a signed error
	function automatic logic [DW-1:0] magnitude(input logic signed [DW-1:0] v);
		if (v[DW-1]) begin
			return DW'(-v);
		end
		return v;
	endfunction

	// Inclusive range test shared by all write checks
	function automatic logic in_range(
		input logic [DW-1:0] v,
		input logic [DW-1:0] lo,
		input logic [DW-1:0] hi
	);
		return v >= lo && v <= hi;
	endfunction

	// Limits, scaling factors and control registers
	logic boot_ff;
	logic [DW-1:0] act_pel_ff;
	logic [DW-1:0] act_vel_ff;
	logic [DW-1:0] pend_pel_ff;
	logic [DW-1:0] pend_vel_ff;
	logic [DW-1:0] dpr_ff;
	logic [DW-1:0] ga_ff;
	logic [DW-1:0] gb_ff;
	logic [DW-1:0] max_pel_ff;
	logic [ST_W-1:0] status_ff;
	logic [ST_W-1:0] mask_ff;
	logic [1:0] action_ff;
	logic alarm_ff;

	// Bus side registers
	logic [DW-1:0] rdata_ff;
	logic save_ff;
	pelm_nv_t nv_out_ff;

	// Decoded strobes and checks
	logic [DW-1:0] pe_mag;
	logic wr_pel;
	logic wr_vel;
	logic wr_dpr;
	logic wr_ga;
	logic wr_gb;
	logic wr_ctrl;
	logic wr_mask;
	logic wr_action;
	logic rd_status;
	logic pel_ok;
	logic vel_ok;
	logic gear_ok;
	logic reject;
	logic rescale;
	logic over;

	// Next values
	logic [DW-1:0] nxt_dpr;
	logic [DW-1:0] nxt_ga;
	logic [DW-1:0] nxt_gb;
	logic [DW-1:0] nxt_rdata;
	logic [ST_W-1:0] ev;

	// Write decode
	always_comb begin
		wr_pel = 1'b0;
		wr_vel = 1'b0;
		wr_dpr = 1'b0;
		wr_ga = 1'b0;
		wr_gb = 1'b0;
		wr_ctrl = 1'b0;
		wr_mask = 1'b0;
		wr_action = 1'b0;
		if (i_wr && i_addr == OFS_PEL) begin
			wr_pel = 1'b1;
		end else if (i_wr && i_addr == OFS_VEL) begin
			wr_vel = 1'b1;
		end else if (i_wr && i_addr == OFS_DPR) begin
			wr_dpr = 1'b1;
		end else if (i_wr && i_addr == OFS_GEAR_A) begin
			wr_ga = 1'b1;
		end else if (i_wr && i_addr == OFS_GEAR_B) begin
			wr_gb = 1'b1;
		end else if (i_wr && i_addr == OFS_CTRL) begin
			wr_ctrl = 1'b1;
		end else if (i_wr && i_addr == OFS_MASK) begin
			wr_mask = 1'b1;
		end else if (i_wr && i_addr == OFS_ACTION) begin
			wr_action = 1'b1;
		end
	end

	// Status read clears the sticky bits
	assign rd_status = i_rd && i_addr == OFS_STATUS;

	// Range checks; sequences only read the limit
	assign pel_ok = !i_seq_access && in_range(i_wdata, VAL_MIN, max_pel_ff);
	assign vel_ok = in_range(i_wdata, VAL_MIN, VAL_SAT);
	assign gear_ok = in_range(i_wdata, VAL_MIN, VAL_SAT); // Zero gear would divide by zero
	assign reject = (wr_pel && !pel_ok) || (wr_vel && !vel_ok)
		|| ((wr_dpr || wr_ga || wr_gb) && !gear_ok);

	// Scaling factors as they stand after this write
	assign nxt_dpr = (wr_dpr && gear_ok) ? i_wdata : dpr_ff;
	assign nxt_ga = (wr_ga && gear_ok) ? i_wdata : ga_ff;
	assign nxt_gb = (wr_gb && gear_ok) ? i_wdata : gb_ff;
	assign rescale = (wr_dpr || wr_ga || wr_gb) && gear_ok;

	// Either direction of deviation counts
	assign pe_mag = magnitude(i_pos_err);
	assign over = i_pos_err_valid && !boot_ff && pe_mag > act_pel_ff;

	// Limit and scaling writes in the boot cycle are dropped, so they raise no event
	assign ev = boot_ff ? '0 : {rescale, reject, over};

	// One cycle after reset the stored image is taken over
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			boot_ff <= 1'b1;
		end else if (i_clk_en) begin
			boot_ff <= 1'b0;
		end
	end

	// Active limit changes only at the load after reset
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			act_pel_ff <= PEL_DEF;
		end else if (i_clk_en && boot_ff) begin
			act_pel_ff <= i_nv_valid ? i_nv_data.pel : PEL_DEF;
		end
	end

	// Velocity limit follows the same save and reset path
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			act_vel_ff <= VEL_DEF;
		end else if (i_clk_en && boot_ff) begin
			act_vel_ff <= i_nv_valid ? i_nv_data.vel : VEL_DEF;
		end
	end

	// Pending limit: written, rescaled, seeded like active from image or default
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			pend_pel_ff <= PEL_DEF;
		end else if (i_clk_en) begin
			if (boot_ff) begin
				pend_pel_ff <= i_nv_valid ? i_nv_data.pel : PEL_DEF;
			end else if (rescale) begin
				// Overwrites host values, hence program factors first
				pend_pel_ff <= scale_revs(nxt_dpr, nxt_ga, nxt_gb, RESC_PEL_REVS);
			end else if (wr_pel && pel_ok) begin
				pend_pel_ff <= i_wdata;
			end
		end
	end

	// Pending velocity limit, same sources
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			pend_vel_ff <= VEL_DEF;
		end else if (i_clk_en) begin
			if (boot_ff) begin
				pend_vel_ff <= i_nv_valid ? i_nv_data.vel : VEL_DEF;
			end else if (rescale) begin
				pend_vel_ff <= scale_revs(nxt_dpr, nxt_ga, nxt_gb, RESC_VEL_RPS);
			end else if (wr_vel && vel_ok) begin
				pend_vel_ff <= i_wdata;
			end
		end
	end

	// Scaling factors and the maximum limit
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			dpr_ff <= DPR_DEF;
			ga_ff <= GEAR_DEF;
			gb_ff <= GEAR_DEF;
			max_pel_ff <= scale_revs(DPR_DEF, GEAR_DEF, GEAR_DEF, DW'(MAX_REVS));
		end else if (i_clk_en && !boot_ff) begin
			dpr_ff <= nxt_dpr;
			ga_ff <= nxt_ga;
			gb_ff <= nxt_gb;
			if (wr_dpr && gear_ok) begin
				max_pel_ff <= scale_revs(i_wdata, GEAR_DEF, GEAR_DEF, DW'(MAX_REVS));
			end
		end
	end

	// Alarm action setting, applied by the alarm handler
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			action_ff <= ACTION_RST;
		end else if (i_clk_en && wr_action) begin
			action_ff <= i_wdata[1:0];
		end
	end

	// Interrupt mask, same layout as status
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			mask_ff <= MASK_RST;
		end else if (i_clk_en && wr_mask) begin
			mask_ff <= i_wdata[ST_W-1:0];
		end
	end

	// Alarm latch; a new excess beats the clear command
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			alarm_ff <= 1'b0;
		end else if (i_clk_en) begin
			if (over) begin
				alarm_ff <= 1'b1;
			end else if (wr_ctrl && i_wdata[CTRL_ALM_CLR]) begin
				alarm_ff <= 1'b0;
			end
		end
	end

	// Sticky status; read clears, set wins
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			status_ff <= ST_RST;
		end else if (i_clk_en) begin
			if (rd_status) begin
				status_ff <= ev;
			end else begin
				status_ff <= status_ff | ev;
			end
		end
	end

	// Save command pulses the store for one cycle
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			save_ff <= 1'b0;
		end else if (i_clk_en) begin
			save_ff <= wr_ctrl && i_wdata[CTRL_SAVE];
		end
	end

	// Pending image captured with the pulse, held until the next save
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			nv_out_ff <= '0;
		end else if (i_clk_en && wr_ctrl && i_wdata[CTRL_SAVE]) begin
			nv_out_ff.pel <= pend_pel_ff;
			nv_out_ff.vel <= pend_vel_ff;
		end
	end

	// Read mux; unmapped and write-only offsets read zero
	always_comb begin
		nxt_rdata = '0;
		if (i_addr == OFS_PEL) begin
			nxt_rdata = pend_pel_ff;
		end else if (i_addr == OFS_PEL_ACT) begin
			nxt_rdata = act_pel_ff;
		end else if (i_addr == OFS_MAX_PEL) begin
			nxt_rdata = max_pel_ff;
		end else if (i_addr == OFS_DPR) begin
			nxt_rdata = dpr_ff;
		end else if (i_addr == OFS_GEAR_A) begin
			nxt_rdata = ga_ff;
		end else if (i_addr == OFS_GEAR_B) begin
			nxt_rdata = gb_ff;
		end else if (i_addr == OFS_VEL) begin
			nxt_rdata = pend_vel_ff;
		end else if (i_addr == OFS_STATUS) begin
			nxt_rdata = DW'(status_ff);
		end else if (i_addr == OFS_MASK) begin
			nxt_rdata = DW'(mask_ff);
		end else if (i_addr == OFS_ACTION) begin
			nxt_rdata = DW'(action_ff);
		end else if (i_addr == OFS_PE) begin
			nxt_rdata = i_pos_err;
		end else if (i_addr == OFS_VEL_ACT) begin
			nxt_rdata = act_vel_ff;
		end
	end

	// Read data valid only the cycle after the strobe
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			rdata_ff <= '0;
		end else if (i_clk_en) begin
			rdata_ff <= i_rd ? nxt_rdata : '0;
		end
	end

	// Outputs
	assign o_rdata = rdata_ff;
	assign o_nv_save = save_ff;
	assign o_nv_data = nv_out_ff;
	assign o_pos_err_limit = act_pel_ff;
	assign o_velocity_limit = act_vel_ff;
	assign o_alarm.active = alarm_ff;
	assign o_alarm.code = alarm_ff ? ALM_CODE_PE : 8'h00;
	assign o_alarm.action = action_ff; // Handler applies it
	assign o_irq = |(status_ff & mask_ff);
endmodule // pelm_monitor

// File: inc/pelm_pkg.sv
// Summary of operation
// - Accept limit 0.001 up to maximum
// - Default limit 3 units without save
// - New limit active after save, reset
// - Sequences may read limit, never write
// - Alarm code 10h when error exceeds limit
// - Alarm response follows alarm action setting
// - Rescale limits on distance or gear change
// - Rescale to 3 revs and 100 rps
// - Recompute maximum limit on distance change
package pelm_pkg;
	// Values are unsigned milli user units
	localparam int unsigned DW = 32;
	localparam int unsigned AW = 6;
	localparam logic [DW-1:0] VAL_MIN = 32'h0000_0001;
	localparam logic [DW-1:0] VAL_SAT = 32'hFFFF_FFFF;
	localparam logic [DW-1:0] PEL_DEF = 32'h0000_0BB8;
	localparam logic [DW-1:0] VEL_DEF = 32'h0001_86A0;
	localparam logic [DW-1:0] DPR_DEF = 32'h0000_03E8;
	localparam logic [DW-1:0] GEAR_DEF = 32'h0000_0001;
	localparam logic [DW-1:0] RESC_PEL_REVS = 32'h0000_0003;
	localparam logic [DW-1:0] RESC_VEL_RPS = 32'h0000_0064;
	localparam int unsigned MAX_REVS_DEF = 16;
	localparam logic [7:0] ALM_CODE_PE = 8'h10;
	// Register offsets
	localparam logic [AW-1:0] OFS_PEL = 6'h00;
	localparam logic [AW-1:0] OFS_PEL_ACT = 6'h04;
	localparam logic [AW-1:0] OFS_MAX_PEL = 6'h08;
	localparam logic [AW-1:0] OFS_DPR = 6'h0C;
	localparam logic [AW-1:0] OFS_GEAR_A = 6'h10;
	localparam logic [AW-1:0] OFS_GEAR_B = 6'h14;
	localparam logic [AW-1:0] OFS_VEL = 6'h18;
	localparam logic [AW-1:0] OFS_CTRL = 6'h1C;
	localparam logic [AW-1:0] OFS_STATUS = 6'h20;
	localparam logic [AW-1:0] OFS_MASK = 6'h24;
	localparam logic [AW-1:0] OFS_ACTION = 6'h28;
	localparam logic [AW-1:0] OFS_PE = 6'h2C;
	localparam logic [AW-1:0] OFS_VEL_ACT = 6'h30;
	// Control and status bit positions
	localparam int unsigned CTRL_SAVE = 0;
	localparam int unsigned CTRL_ALM_CLR = 1;
	localparam int unsigned ST_ALARM = 0;
	localparam int unsigned ST_REJECT = 1;
	localparam int unsigned ST_RESCALE = 2;
	localparam int unsigned ST_W = 3;
	localparam logic [ST_W-1:0] ST_RST = 3'h0;
	localparam logic [ST_W-1:0] MASK_RST = 3'h0;
	localparam logic [1:0] ACTION_RST = 2'h0;
	// Saved parameter image, toward and from the store
	typedef struct packed {
		logic [DW-1:0] pel;
		logic [DW-1:0] vel;
	} pelm_nv_t;
	// Alarm report toward the alarm handler
	typedef struct packed {
		logic active;
		logic [7:0] code;
		logic [1:0] action;
	} pelm_alarm_t;
endpackage

// File: verification/pelm_monitor_properties.sv
`timescale 1ns/10ps
module pelm_monitor_chk #(
	parameter int unsigned MAX_REVS = pelm_pkg::MAX_REVS_DEF // Max limit in revs
) (
	input wire logic i_core_clk, // Clock
	input wire logic i_sys_rst, // Reset
	input wire logic i_clk_en, // Clock enable
	input wire logic [pelm_pkg::AW-1:0] i_addr, // Address
	input wire logic [pelm_pkg::DW-1:0] i_wdata, // Write data
	input wire logic i_wr, // Write strobe
	input wire logic i_rd, // Read strobe
	input wire logic [pelm_pkg::DW-1:0] o_rdata, // Read data
	input wire logic signed [pelm_pkg::DW-1:0] i_pos_err, // Error
	input wire logic i_pos_err_valid, // Error valid
	input wire logic o_nv_save, // Save pulse
	input wire logic [pelm_pkg::DW-1:0] o_pos_err_limit, // Active limit
	input wire pelm_pkg::pelm_alarm_t o_alarm // Alarm report
);
	import pelm_pkg::*;
	logic boot_ff;
	logic [DW-1:0] mag;
	logic exc;
	logic clr;
	logic sv;
	// Boot cycle ignores excess, so it is kept out of the antecedents
	always_ff @(posedge i_core_clk) begin
		boot_ff <= i_sys_rst;
	end
	// Magnitude, so both directions count
	assign mag = i_pos_err[DW-1] ? -i_pos_err : i_pos_err;
	assign exc = i_clk_en && i_pos_err_valid && mag > o_pos_err_limit && !boot_ff;
	assign clr = i_clk_en && i_wr && i_addr == OFS_CTRL && i_wdata[CTRL_ALM_CLR];
	assign sv = i_clk_en && i_wr && i_addr == OFS_CTRL && i_wdata[CTRL_SAVE];
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_sys_rst);
	sequence s_rd(a);
		i_rd && i_addr == a;
	endsequence
	property p_alm_set;
		exc |=> o_alarm.active && o_alarm.code == ALM_CODE_PE;
	endproperty
	a_alm_set: assert property (p_alm_set) else $error("alarm missed");
	property p_alm_hold;
		o_alarm.active && !clr |=> o_alarm.active;
	endproperty
	a_alm_hold: assert property (p_alm_hold) else $error("alarm dropped");
	property p_alm_clr;
		clr && !exc |=> !o_alarm.active && o_alarm.code == 8'h00;
	endproperty
	a_alm_clr: assert property (p_alm_clr) else $error("alarm not cleared");
	property p_action;
		logic [1:0] v;
		(i_clk_en && i_wr && i_addr == OFS_ACTION, v = i_wdata[1:0]) |=> o_alarm.action == v;
	endproperty
	a_action: assert property (p_action) else $error("action not followed");
	property p_save;
		sv |=> o_nv_save;
	endproperty
	a_save: assert property (p_save) else $error("save missed");
	property p_save_cause;
		o_nv_save |-> $past(sv);
	endproperty
	a_save_cause: assert property (p_save_cause) else $error("stray save");
	property p_lim_hold;
		!boot_ff && !$past(boot_ff) |-> $stable(o_pos_err_limit);
	endproperty
	a_lim_hold: assert property (p_lim_hold) else $error("limit changed early");
	property p_reject;
		(i_wr && i_addr == OFS_PEL && i_wdata == 32'h0000_0000) ##2 s_rd(OFS_PEL)
			|=> o_rdata != 32'h0000_0000;
	endproperty
	a_reject: assert property (p_reject) else $error("zero limit taken");
	property p_max;
		logic [DW-1:0] v;
		(i_wr && i_addr == OFS_DPR && i_wdata != 0 && i_wdata < 32'h0010_0000 && !boot_ff,
			v = i_wdata) ##2 s_rd(OFS_MAX_PEL) |=> o_rdata == v * MAX_REVS;
	endproperty
	a_max: assert property (p_max) else $error("max limit wrong");
endmodule // pelm_monitor_chk
bind pelm_monitor pelm_monitor_chk #(.MAX_REVS(MAX_REVS)) i_pelm_monitor_chk (
	.i_core_clk, .i_sys_rst, .i_clk_en, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_pos_err,
	.i_pos_err_valid, .o_nv_save, .o_pos_err_limit, .o_alarm
);

// File: verification/pelm_nv_store.sv
`timescale 1ns/10ps
module pelm_nv_store (
	input wire logic i_core_clk, // Clock
	input wire logic i_erase, // Wipe image
	input wire logic i_save, // Save pulse
	input wire pelm_pkg::pelm_nv_t i_data, // Image to keep
	output logic o_valid, // Image present
	output pelm_pkg::pelm_nv_t o_data // Kept image
);
	import pelm_pkg::*;
	// Survives device reset; junk data while empty
	always_ff @(posedge i_core_clk) begin
		if (i_erase) begin
			o_valid <= 1'b0;
			o_data <= {2{32'hA5A5_5A5A}};
		end else if (i_save) begin
			o_valid <= 1'b1;
			o_data <= i_data;
		end
	end
endmodule // pelm_nv_store

// File: verification/position_error_limit_monitor_test.sv
`timescale 1ns/10ps
module position_error_limit_monitor_test;
	import pelm_pkg::*;
	localparam int unsigned MR = 16;
	localparam logic [DW-1:0] D = 32'h0000_0168;
	localparam logic [DW-1:0] MX = DPR_DEF * MR;
	localparam logic [DW-1:0] Z = 32'h0000_0000;
	logic i_core_clk = 1'b0;
	logic i_sys_rst = 1'b1;
	logic i_clk_en = 1'b1;
	logic erase = 1'b1;
	logic [AW-1:0] i_addr = '0;
	logic [DW-1:0] i_wdata = '0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic i_seq_access = 1'b0;
	logic signed [DW-1:0] i_pos_err = '0;
	logic i_pos_err_valid = 1'b0;
	logic i_nv_valid;
	logic o_nv_save;
	logic o_irq;
	logic [DW-1:0] o_rdata;
	logic [DW-1:0] o_pos_err_limit;
	logic [DW-1:0] o_velocity_limit;
	pelm_nv_t i_nv_data;
	pelm_nv_t o_nv_data;
	pelm_alarm_t o_alarm;
	int fails = 0;
	int comparisons = 0;
	always #10 i_core_clk = ~i_core_clk;
	pelm_monitor #(.MAX_REVS(MR)) i_pelm_monitor (
		.i_core_clk, .i_sys_rst, .i_clk_en, .i_addr, .i_wdata, .i_wr, .i_rd,
		.i_seq_access, .o_rdata, .i_pos_err, .i_pos_err_valid, .i_nv_valid, .i_nv_data,
		.o_nv_save, .o_nv_data, .o_pos_err_limit, .o_velocity_limit, .o_alarm, .o_irq
	);
	pelm_nv_store i_pelm_nv_store (
		.i_core_clk, .i_erase(erase), .i_save(o_nv_save), .i_data(o_nv_data),
		.o_valid(i_nv_valid), .o_data(i_nv_data)
	);
	task automatic chk(input string n, input logic [DW-1:0] e, input logic [DW-1:0] g);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
		@(posedge i_core_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
	endtask
	// Data stand only in the cycle after the strobe
	task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] e, input string n);
		@(posedge i_core_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_core_clk);
		i_rd <= 1'b0;
		#1 chk(n, e, o_rdata);
	endtask
	task automatic err(input logic [DW-1:0] v);
		@(posedge i_core_clk);
		i_pos_err <= v;
		i_pos_err_valid <= 1'b1;
		@(posedge i_core_clk);
		i_pos_err_valid <= 1'b0;
		#1;
	endtask
	// Ends just past the boot edge, store kept
	task automatic boot();
		@(posedge i_core_clk);
		i_sys_rst <= 1'b1;
		repeat (5) @(posedge i_core_clk);
		i_sys_rst <= 1'b0;
		erase <= 1'b0;
		@(posedge i_core_clk);
		#1;
	endtask
	task automatic t_range();
		chk("dflt", PEL_DEF, o_pos_err_limit);
		rd(OFS_MAX_PEL, MX, "max");
		wr(OFS_PEL, Z);
		rd(OFS_PEL, PEL_DEF, "zero");
		wr(OFS_PEL, MX + 1);
		rd(OFS_PEL, PEL_DEF, "over");
		wr(OFS_PEL, VAL_MIN);
		rd(OFS_PEL, VAL_MIN, "min");
		wr(OFS_PEL, MX);
		@(posedge i_core_clk);
		i_seq_access <= 1'b1;
		wr(OFS_PEL, VAL_MIN);
		rd(OFS_PEL, MX, "seq");
		@(posedge i_core_clk);
		i_seq_access <= 1'b0;
		rd(OFS_STATUS, 32'h0000_0002, "rej");
	endtask
	// Pending value reaches the active limit only through save and reset
	task automatic t_save();
		chk("pend", PEL_DEF, o_pos_err_limit);
		wr(OFS_VEL, 32'h0000_1F40);
		wr(OFS_CTRL, 32'h0000_0001);
		#1 chk("save", 32'h0000_0001, {31'h0000_0000, o_nv_save});
		chk("img", MX, o_nv_data.pel);
		chk("pendv", VEL_DEF, o_velocity_limit);
		boot();
		chk("act", MX, o_pos_err_limit);
		chk("actv", 32'h0000_1F40, o_velocity_limit);
	endtask
	task automatic t_alarm();
		wr(OFS_MASK, 32'h0000_0001);
		wr(OFS_ACTION, 32'h0000_0002);
		// Frozen write must not land; the action check below shows it
		i_clk_en <= 1'b0;
		wr(OFS_ACTION, 32'h0000_0001);
		i_clk_en <= 1'b1;
		err(-MX);
		chk("edge", Z, {31'h0000_0000, o_alarm.active});
		err(-(MX + 1));
		chk("neg", {21'h00_0000, 1'b1, ALM_CODE_PE, 2'h2}, o_alarm);
		chk("irq", 32'h0000_0001, {31'h0000_0000, o_irq});
		rd(OFS_STATUS, 32'h0000_0001, "st");
		chk("irq0", Z, {31'h0000_0000, o_irq});
		wr(OFS_CTRL, 32'h0000_0002);
		#1 chk("clr", Z, {31'h0000_0000, o_alarm.active});
		wr(OFS_MASK, Z);
		err(MX + 1);
		chk("pos", 32'h0000_0001, {31'h0000_0000, o_alarm.active});
		chk("mask", Z, {31'h0000_0000, o_irq});
		rd(OFS_STATUS, 32'h0000_0001, "st2");
	endtask
	task automatic t_rescale();
		wr(OFS_DPR, D);
		rd(OFS_MAX_PEL, D * MR, "max");
		rd(OFS_PEL, D * RESC_PEL_REVS, "pel");
		rd(OFS_VEL, D * RESC_VEL_RPS, "vel");
		wr(OFS_GEAR_A, 32'h0000_0002);
		wr(OFS_GEAR_B, 32'h0000_0003);
		rd(OFS_PEL, D * 2 * RESC_PEL_REVS / 3, "pelg");
		rd(OFS_VEL, D * 2 * RESC_VEL_RPS / 3, "velg");
		rd(OFS_MAX_PEL, D * MR, "maxg");
		wr(OFS_DPR, Z);
		rd(OFS_STATUS, 32'h0000_0006, "st3");
		rd(6'h3C, Z, "unmap");
	endtask
	task automatic print_verdict();
		if (fails == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		boot();
		t_range();
		t_save();
		t_alarm();
		t_rescale();
		print_verdict();
	end
	// Run needs well under this
	initial begin
		#200us;
		fails++;
		print_verdict();
	end
endmodule // position_error_limit_monitor_test
